// [rsx_params.svh]
// constants for the rotate and sleep execution block
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH

// apb byte offsets
`define RSX_OFF_INSTR     8'h00
`define RSX_OFF_WREG      8'h04
`define RSX_OFF_STATUS    8'h08
`define RSX_OFF_FADDR     8'h0c
`define RSX_OFF_FDATA     8'h10
`define RSX_OFF_WDOG      8'h14
`define RSX_OFF_CTRL      8'h18

// status field positions
`define RSX_ST_CARRY      0
`define RSX_ST_DCARRY     1
`define RSX_ST_ZERO       2
`define RSX_ST_PD_N       3
`define RSX_ST_TO_N       4
`define RSX_ST_ASLEEP     5
`define RSX_ST_BUSY       6
`define RSX_ST_UNSUP      7

// control field positions
`define RSX_CTRL_WAKE     0

// instruction encoding
`define RSX_OPC_RLF       6'h0d
`define RSX_OPC_RRF       6'h0c
`define RSX_SLEEP_WORD    14'h0063

// reset values
`define RSX_RST_INSTR     14'h0000
`define RSX_RST_WREG      8'h00
`define RSX_RST_FLAG_N    1'b1

// watchdog sizing
`define RSX_WDOG_W        8
`define RSX_PRE_W         7

`endif

// [rsx_pkg.sv]
// types shared by the rotate and sleep execution block
package rsx_pkg;

    // one instruction cycle, one state per phase
    typedef enum logic [4:0] {
        RSX_IDLE = 5'h01,
        RSX_Q1   = 5'h02,
        RSX_Q2   = 5'h04,
        RSX_Q3   = 5'h08,
        RSX_Q4   = 5'h10
    } rsx_phase_type;

    typedef enum logic [1:0] {
        RSX_OP_NONE  = 2'h0,
        RSX_OP_RLF   = 2'h1,
        RSX_OP_RRF   = 2'h2,
        RSX_OP_SLEEP = 2'h3
    } rsx_op_type;

endpackage : rsx_pkg

// [rsx_rotator.sv]
// one-bit rotate through carry
`timescale 1ns/1ns
module rsx_rotator #(
    parameter int DATA_W = 8
) (
    // operand
    input  wire logic [DATA_W-1:0] val,
    input  wire logic              carry_in,
    input  wire logic              dir_left,
    // result
    output logic      [DATA_W-1:0] result,
    output logic                   carry_out
);

    always_comb begin
        if (dir_left) begin
            result    = {val[DATA_W-2:0], carry_in};
            carry_out = val[DATA_W-1];
        end else begin
            result    = {carry_in, val[DATA_W-1:1]};
            carry_out = val[0];
        end
    end

endmodule : rsx_rotator

// [rsx_watchdog.sv]
// watchdog counter behind its prescaler
`timescale 1ns/1ns
`include "rsx_params.svh"
module rsx_watchdog #(
    parameter int CNT_W = `RSX_WDOG_W,
    parameter int PRE_W = `RSX_PRE_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // control
    input  wire logic             clr,
    // state
    output logic      [CNT_W-1:0] count
);

    logic [PRE_W-1:0] pre_r;
    logic [CNT_W-1:0] count_r;

    // counter and prescaler are cleared together
    always_ff @(posedge clk) begin
        if (srst || clr) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // wraps silently; nothing in the project acts on a time-out
    always_ff @(posedge clk) begin
        if (srst || clr) begin
            count_r <= '0;
        end else if (&pre_r) begin
            count_r <= count_r + 1'b1;
        end
    end

    assign count = count_r;

endmodule : rsx_watchdog

// [rsx_exec.sv]
// rotate and sleep decode and execute with apb register access
`timescale 1ns/1ns
`include "rsx_params.svh"
module rsx_exec #(
    parameter int ADDR_W  = 8,
    parameter int DATA_W  = 8,
    parameter int FADDR_W = 7,
    parameter int WDOG_W  = `RSX_WDOG_W,
    parameter int PRE_W   = `RSX_PRE_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // apb slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // core state
    output logic                   osc_run,
    output logic                   asleep
);

    localparam int FDEPTH = 1 << FADDR_W;

    // op_of decodes for the sequencer; addr_is is shared by the bus and the sequencer
    function automatic rsx_pkg::rsx_op_type op_of(input logic [13:0] word);
        rsx_pkg::rsx_op_type op;
        op = rsx_pkg::RSX_OP_NONE;
        if (word[13:8] == `RSX_OPC_RLF) begin
            op = rsx_pkg::RSX_OP_RLF;
        end else if (word[13:8] == `RSX_OPC_RRF) begin
            op = rsx_pkg::RSX_OP_RRF;
        end else if (word == `RSX_SLEEP_WORD) begin
            op = rsx_pkg::RSX_OP_SLEEP;
        end
        return op;
    endfunction : op_of

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction : addr_is

    // state
    rsx_pkg::rsx_phase_type phase_r;
    rsx_pkg::rsx_op_type    op_r;
    logic [13:0]            instr_r;
    logic [DATA_W-1:0]      wreg_r;
    logic [DATA_W-1:0]      operand_r;
    logic [DATA_W-1:0]      result_r;
    logic                   carry_res_r;
    logic                   carry_r;
    logic                   dcarry_r;
    logic                   zero_r;
    logic                   pd_n_r;
    logic                   to_n_r;
    logic                   sleep_r;
    logic                   unsup_r;
    logic [FADDR_W-1:0]     faddr_r;
    logic [31:0]            prdata_r;
    logic [DATA_W-1:0]      file_mem [FDEPTH];

    // datapath
    logic [DATA_W-1:0]      rot_val;
    logic                   rot_carry;
    logic [WDOG_W-1:0]      wdog_count;
    logic                   wdog_clr;
    logic                   rot_dest_file;
    logic [FADDR_W-1:0]     rot_faddr;

    // bus decode
    logic                   setup;
    logic                   access;
    logic                   wr_en;
    logic                   busy;
    logic                   hit;
    logic                   instr_refused;

    assign busy          = (phase_r != rsx_pkg::RSX_IDLE);
    assign rot_dest_file = instr_r[7];
    assign rot_faddr     = instr_r[FADDR_W-1:0];

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    assign setup  = psel && !penable;
    assign access = psel && penable;

    always_comb begin
        if (addr_is(paddr, `RSX_OFF_INSTR)) begin
            hit = 1'b1;
        end else if (addr_is(paddr, `RSX_OFF_WREG)) begin
            hit = 1'b1;
        end else if (addr_is(paddr, `RSX_OFF_STATUS)) begin
            hit = 1'b1;
        end else if (addr_is(paddr, `RSX_OFF_FADDR)) begin
            hit = 1'b1;
        end else if (addr_is(paddr, `RSX_OFF_FDATA)) begin
            hit = 1'b1;
        end else if (addr_is(paddr, `RSX_OFF_WDOG)) begin
            hit = 1'b1;
        end else if (addr_is(paddr, `RSX_OFF_CTRL)) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // a new instruction while one runs or while asleep is refused
    assign instr_refused = pwrite && addr_is(paddr, `RSX_OFF_INSTR) && (busy || sleep_r);

    // read data is captured in setup, so every access is one cycle long
    assign pready  = access;
    assign pslverr = access && (!hit || instr_refused);
    assign wr_en   = access && pwrite && hit && !instr_refused;
    assign prdata  = prdata_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (addr_is(paddr, `RSX_OFF_INSTR)) begin
                prdata_r <= {18'h0_0000, instr_r};
            end else if (addr_is(paddr, `RSX_OFF_WREG)) begin
                prdata_r <= {{(32-DATA_W){1'b0}}, wreg_r};
            end else if (addr_is(paddr, `RSX_OFF_STATUS)) begin
                prdata_r <= {24'h00_0000, unsup_r, busy, sleep_r, to_n_r, pd_n_r,
                             zero_r, dcarry_r, carry_r};
            end else if (addr_is(paddr, `RSX_OFF_FADDR)) begin
                prdata_r <= {{(32-FADDR_W){1'b0}}, faddr_r};
            end else if (addr_is(paddr, `RSX_OFF_FDATA)) begin
                prdata_r <= {{(32-DATA_W){1'b0}}, file_mem[faddr_r]};
            end else if (addr_is(paddr, `RSX_OFF_WDOG)) begin
                prdata_r <= {{(32-WDOG_W){1'b0}}, wdog_count};
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            faddr_r <= '0;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_FADDR)) begin
            faddr_r <= pwdata[FADDR_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // instruction cycle sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= rsx_pkg::RSX_IDLE;
        end else begin
            case (phase_r)
                rsx_pkg::RSX_IDLE: begin
                    if (wr_en && addr_is(paddr, `RSX_OFF_INSTR)) begin
                        phase_r <= rsx_pkg::RSX_Q1;
                    end
                end
                rsx_pkg::RSX_Q1: begin
                    phase_r <= rsx_pkg::RSX_Q2;
                end
                rsx_pkg::RSX_Q2: begin
                    phase_r <= rsx_pkg::RSX_Q3;
                end
                rsx_pkg::RSX_Q3: begin
                    phase_r <= rsx_pkg::RSX_Q4;
                end
                rsx_pkg::RSX_Q4: begin
                    phase_r <= rsx_pkg::RSX_IDLE;
                end
                default: begin
                    phase_r <= rsx_pkg::RSX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            instr_r <= `RSX_RST_INSTR;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_INSTR)) begin
            instr_r <= pwdata[13:0];
        end
    end

    // q1: decode
    always_ff @(posedge clk) begin
        if (srst) begin
            op_r <= rsx_pkg::RSX_OP_NONE;
        end else if (phase_r == rsx_pkg::RSX_Q1) begin
            op_r <= op_of(instr_r);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            unsup_r <= 1'b0;
        end else if (phase_r == rsx_pkg::RSX_Q1) begin
            unsup_r <= (op_of(instr_r) == rsx_pkg::RSX_OP_NONE);
        end
    end

    // q2: read the file register; sleep does nothing here
    always_ff @(posedge clk) begin
        if (srst) begin
            operand_r <= '0;
        end else if (phase_r == rsx_pkg::RSX_Q2 &&
                     (op_r == rsx_pkg::RSX_OP_RLF || op_r == rsx_pkg::RSX_OP_RRF)) begin
            operand_r <= file_mem[rot_faddr];
        end
    end

    // q3: process
    rsx_rotator #(
        .DATA_W    (DATA_W)
    ) u_rot (
        .val       (operand_r),
        .carry_in  (carry_r),
        .dir_left  (op_r == rsx_pkg::RSX_OP_RLF),
        .result    (rot_val),
        .carry_out (rot_carry)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            result_r    <= '0;
            carry_res_r <= 1'b0;
        end else if (phase_r == rsx_pkg::RSX_Q3 &&
                     (op_r == rsx_pkg::RSX_OP_RLF || op_r == rsx_pkg::RSX_OP_RRF)) begin
            result_r    <= rot_val;
            carry_res_r <= rot_carry;
        end
    end

    // q4: write destination; hardware wins over a same-cycle bus write
    always_ff @(posedge clk) begin
        if (srst) begin
            wreg_r <= `RSX_RST_WREG;
        end else if (phase_r == rsx_pkg::RSX_Q4 && !rot_dest_file &&
                     (op_r == rsx_pkg::RSX_OP_RLF || op_r == rsx_pkg::RSX_OP_RRF)) begin
            wreg_r <= result_r;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_WREG)) begin
            wreg_r <= pwdata[DATA_W-1:0];
        end
    end

    // file memory has no reset; its contents are software's to set
    always_ff @(posedge clk) begin
        if (phase_r == rsx_pkg::RSX_Q4 && rot_dest_file &&
            (op_r == rsx_pkg::RSX_OP_RLF || op_r == rsx_pkg::RSX_OP_RRF)) begin
            file_mem[rot_faddr] <= result_r;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_FDATA)) begin
            file_mem[faddr_r] <= pwdata[DATA_W-1:0];
        end
    end

    // carry and unsup are the only flags a rotate touches
    always_ff @(posedge clk) begin
        if (srst) begin
            carry_r <= 1'b0;
        end else if (phase_r == rsx_pkg::RSX_Q4 &&
                     (op_r == rsx_pkg::RSX_OP_RLF || op_r == rsx_pkg::RSX_OP_RRF)) begin
            carry_r <= carry_res_r;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_STATUS)) begin
            carry_r <= pwdata[`RSX_ST_CARRY];
        end
    end

    // zero and digit carry belong to instructions outside this block
    always_ff @(posedge clk) begin
        if (srst) begin
            dcarry_r <= 1'b0;
            zero_r   <= 1'b0;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_STATUS)) begin
            dcarry_r <= pwdata[`RSX_ST_DCARRY];
            zero_r   <= pwdata[`RSX_ST_ZERO];
        end
    end

    // ---------------------------------------------------------------
    // sleep entry
    // ---------------------------------------------------------------
    assign wdog_clr = (phase_r == rsx_pkg::RSX_Q4) && (op_r == rsx_pkg::RSX_OP_SLEEP);

    // flags are read-only to software; only sleep and reset move them
    always_ff @(posedge clk) begin
        if (srst) begin
            pd_n_r <= `RSX_RST_FLAG_N;
            to_n_r <= `RSX_RST_FLAG_N;
        end else if (wdog_clr) begin
            pd_n_r <= 1'b0;
            to_n_r <= 1'b1;
        end
    end

    // wake is a plain bus bit here; sleep entry wins over a same-cycle wake
    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_r <= 1'b0;
        end else if (wdog_clr) begin
            sleep_r <= 1'b1;
        end else if (wr_en && addr_is(paddr, `RSX_OFF_CTRL) && pwdata[`RSX_CTRL_WAKE]) begin
            sleep_r <= 1'b0;
        end
    end

    rsx_watchdog #(
        .CNT_W (WDOG_W),
        .PRE_W (PRE_W)
    ) u_wdog (
        .clk   (clk),
        .srst  (srst),
        .clr   (wdog_clr),
        .count (wdog_count)
    );

    // oscillator gate: stays stopped for the whole sleep
    assign osc_run = !sleep_r;
    assign asleep  = sleep_r;

endmodule : rsx_exec

// [rsx_exec_chk.sv]
// port-level assertions for the rotate and sleep execution block
`timescale 1ns/1ns
`include "rsx_params.svh"
module rsx_exec_chk #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              srst,
    // apb
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // core state
    input wire logic              osc_run,
    input wire logic              asleep
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic       acc;
    logic       mapped;
    logic       instr_wr;
    logic       sleep_ok;
    logic       wake_wr;
    logic [2:0] busy_r;

    assign acc      = psel && penable;
    assign mapped   = (paddr <= `RSX_OFF_CTRL) && (paddr[1:0] == 2'h0);
    assign instr_wr = acc && pwrite && (paddr == `RSX_OFF_INSTR);
    assign sleep_ok = instr_wr && !pslverr && (pwdata[13:0] == `RSX_SLEEP_WORD);
    assign wake_wr  = acc && pwrite && (paddr == `RSX_OFF_CTRL) && pwdata[`RSX_CTRL_WAKE];

    // q1..q4 still running after an accepted instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r <= 3'h0;
        end else if (instr_wr && !pslverr) begin
            busy_r <= 3'h4;
        end else if (busy_r != 3'h0) begin
            busy_r <= busy_r - 3'h1;
        end
    end

    sequence sleep_quiet;
        (!asleep && osc_run)[*4];
    endsequence

    sequence sleep_entered;
        asleep && !osc_run;
    endsequence

    a_sleep_timing: assert property (sleep_ok |=> sleep_quiet ##1 sleep_entered)
        else $error("sleep not entered at end of q4");
    a_sleep_cause: assert property ($rose(asleep) |-> $past(sleep_ok, 5))
        else $error("sleep entered without a sleep instruction");
    a_osc_follows: assert property (osc_run == !asleep)
        else $error("oscillator runs while asleep");
    a_sleep_holds: assert property (asleep && !wake_wr |=> asleep)
        else $error("sleep left without wake");
    a_busy_refused: assert property (instr_wr && (busy_r != 3'h0 || asleep) |-> pslverr)
        else $error("instruction accepted while busy");
    a_one_cycle: assert property (instr_wr && !pslverr ##5 (instr_wr && !asleep)
        |-> !pslverr)
        else $error("instruction longer than one cycle");
    a_status_sleep: assert property (psel && !penable && !pwrite && asleep
        && paddr == `RSX_OFF_STATUS |=> !prdata[`RSX_ST_PD_N] && prdata[`RSX_ST_TO_N])
        else $error("sleep flags wrong");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && mapped && paddr != `RSX_OFF_INSTR |-> !pslverr)
        else $error("mapped access refused");
    a_wake_clears: assert property (asleep && wake_wr |=> !asleep && osc_run)
        else $error("wake ignored");
endmodule : rsx_exec_chk

// [tb_rsx_exec.sv]
// self-checking bench for the rotate and sleep execution block
`timescale 1ns/1ns
`include "rsx_params.svh"
module tb_rsx_exec;
    typedef struct packed {
        logic [13:0] ins;
        logic [7:0]  fv;
        logic [2:0]  st;
        logic [7:0]  ew;
        logic [7:0]  ef;
        logic [2:0]  est;
    } rsx_row_type;

    logic        clk;
    logic        srst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_run;
    logic        asleep;
    logic [31:0] rd;
    logic        err;
    int          fail_count;
    int          n_tests;
    rsx_row_type rows [4];

    rsx_exec dut (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_run(osc_run), .asleep(asleep));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // one apb transfer; no fixed wait, only the bounded count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) fail_count++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        final_report();
    end

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fail_count = 0;
        n_tests = 0;
        rows[0] = '{{6'h0d, 1'b0, 7'h05}, 8'he6, 3'h0, 8'hcc, 8'he6, 3'h1};
        rows[1] = '{{6'h0d, 1'b1, 7'h7f}, 8'h01, 3'h7, 8'h5a, 8'h03, 3'h6};
        rows[2] = '{{6'h0c, 1'b0, 7'h00}, 8'he6, 3'h2, 8'h73, 8'he6, 3'h2};
        rows[3] = '{{6'h0c, 1'b1, 7'h40}, 8'h01, 3'h5, 8'h5a, 8'h80, 3'h5};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, `RSX_OFF_FADDR, {25'h0, rows[i].ins[6:0]});
            apb(1'b1, `RSX_OFF_FDATA, {24'h0, rows[i].fv});
            apb(1'b1, `RSX_OFF_WREG, 32'h5a);
            apb(1'b1, `RSX_OFF_STATUS, {29'h0, rows[i].st});
            apb(1'b1, `RSX_OFF_INSTR, {18'h0, rows[i].ins});
            repeat (5) @(posedge clk);
            apb(1'b0, `RSX_OFF_WREG, 32'h0);
            chk(rd, {24'h0, rows[i].ew});
            apb(1'b0, `RSX_OFF_FDATA, 32'h0);
            chk(rd, {24'h0, rows[i].ef});
            apb(1'b0, `RSX_OFF_STATUS, 32'h0);
            chk(rd, {24'h0, 5'h03, rows[i].est});
        end
        // second instruction lands in q3 of the first
        apb(1'b1, `RSX_OFF_INSTR, {18'h0, rows[0].ins});
        apb(1'b1, `RSX_OFF_INSTR, {18'h0, rows[0].ins});
        chk({31'h0, err}, 32'h1);
        repeat (5) @(posedge clk);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        // a word outside the three decoded ones runs idle and is flagged
        apb(1'b1, `RSX_OFF_INSTR, 32'h0000_0008);
        chk({31'h0, err}, 32'h0);
        repeat (5) @(posedge clk);
        apb(1'b0, `RSX_OFF_STATUS, 32'h0);
        chk({31'h0, rd[`RSX_ST_UNSUP]}, 32'h1);
        chk({31'h0, rd[`RSX_ST_PD_N] & rd[`RSX_ST_TO_N]}, 32'h1);
        // let the watchdog advance before sleeping
        apb(1'b1, `RSX_OFF_STATUS, 32'h5);
        repeat (300) @(posedge clk);
        apb(1'b1, `RSX_OFF_INSTR, {18'h0, `RSX_SLEEP_WORD});
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({31'h0, osc_run}, 32'h0);
        apb(1'b0, `RSX_OFF_WDOG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `RSX_OFF_STATUS, 32'h0);
        chk(rd, 32'h35);
        // prescaler cleared too: no tick within 128 cycles
        repeat (100) @(posedge clk);
        apb(1'b0, `RSX_OFF_WDOG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `RSX_OFF_INSTR, {18'h0, rows[0].ins});
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `RSX_OFF_CTRL, 32'h1);
        @(negedge clk);
        chk({30'h0, asleep, osc_run}, 32'h1);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, `RSX_OFF_STATUS, 32'h0);
        chk(rd, 32'h18);
        apb(1'b0, `RSX_OFF_WREG, 32'h0);
        chk(rd, 32'h0);
        final_report();
    end
endmodule : tb_rsx_exec

bind rsx_exec rsx_exec_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_run(osc_run), .asleep(asleep));
